// ===== sys_pin_pkg.sv
// Shared constants and carrier types for the system pin control block
`default_nettype none
package sys_pin_pkg;
    localparam int          PROG_CNT_WIDTH    = 16;
    localparam logic [15:0] PROG_CNT_RESET    = 16'h0000;
    localparam int          CLK_SEL_BIT       = 14;
    localparam int          BOOT_EN_BIT       = 3;
    localparam logic        CLK_SEL_RESET     = 1'b0;
    localparam int          PWM_PER_GROUP     = 8;
    localparam int          SYNC_STAGES       = 3;
    localparam int          WD_PULSE_NS       = 40;
    localparam int          CLK_PERIOD_NS     = 10;
    localparam int          WD_PULSE_CYCLES   = (WD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0]  WD_PULSE_CNT      = WD_PULSE_CYCLES[7:0];
    localparam logic [3:0]  PEND_RESET        = 4'h0;

    // Pending event bits: fault A, fault B, irq one, irq two
    typedef struct packed {
        logic fault_a;
        logic fault_b;
        logic irq_one;
        logic irq_two;
    } pend_t;

    typedef struct packed {
        logic [PWM_PER_GROUP-1:0] out;
        logic [PWM_PER_GROUP-1:0] oe;
    } pwm_pins_t;

    typedef enum logic [1:0] {
        RST_RUN,
        RST_HOLD,
        RST_WD_PULSE
    } rst_state_t;
endpackage : sys_pin_pkg
`default_nettype wire

// ===== pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`default_nettype none
module pin_sync (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic pin,
    output logic      level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // First stage feeds only the second
    always_ff @(posedge mclk) begin
        if (rst) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            level <= 1'b1;
        end else if (s2_q == s3_q) begin
            level <= s3_q;
        end
    end
endmodule : pin_sync
`default_nettype wire

// ===== edge_pend.sv
// Edge detector with sticky pending flag
`default_nettype none
module edge_pend (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic level,
    input  wire logic rise_sel,
    input  wire logic clear,
    output logic      hit,
    output logic      pend
);
    logic prev_q;

    // Tracks the level in reset too, so release gives no false edge
    always_ff @(posedge mclk) begin
        prev_q <= level;
    end

    assign hit = ~rst & (rise_sel ? (level & ~prev_q) : (~level & prev_q));

    // Set wins over a simultaneous clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            pend <= 1'b0;
        end else if (hit) begin
            pend <= 1'b1;
        end else if (clear) begin
            pend <= 1'b0;
        end
    end
endmodule : edge_pend
`default_nettype wire

// ===== system_pin_control.sv
// System pin logic: reset, drive faults, external interrupts, clock out, flag pin
`default_nettype none
// Notes on behaviour
// - Reset pin low halts execution, counter zero
// - Reset release starts fetch at zero
// - Watchdog overflow pulses reset pin outward
// - Fault A floats group A PWM, interrupts
// - Fault B floats group B PWM, interrupts
// - Fault inputs act on falling edge only
// - External interrupts edge detect, polarity selectable
// - Irq two also ADC start or GPIO
// - Clock pin outputs CPU or watchdog clock
// - Clock pin is GPIO when not clocking
// - Boot enable sampled in reset, then flag
// - Output disable floats crystal driver
// - All GPIO inputs after any reset
module system_pin_control (
    input  wire logic                              mclk,
    input  wire logic                              rst,
    input  wire logic                              system_reset_pin_in,
    output logic                                   system_reset_pin_out,
    output logic                                   system_reset_pin_oe,
    input  wire logic                              watchdog_overflow,
    output logic                                   cpu_halt,
    output logic                                   program_counter_clear,
    output logic [sys_pin_pkg::PROG_CNT_WIDTH-1:0] program_counter_reset_value,
    input  wire logic                              drive_fault_in_a,
    input  wire logic                              drive_fault_in_b,
    input  wire sys_pin_pkg::pwm_pins_t            event_group_a_pwm,
    input  wire sys_pin_pkg::pwm_pins_t            event_group_b_pwm,
    output sys_pin_pkg::pwm_pins_t                 event_group_a_pins,
    output sys_pin_pkg::pwm_pins_t                 event_group_b_pins,
    input  wire logic                              fault_release_a,
    input  wire logic                              fault_release_b,
    input  wire logic                              ext_irq_one,
    input  wire logic                              ext_irq_two,
    input  wire logic                              irq_one_rise_sel,
    input  wire logic                              irq_two_rise_sel,
    input  wire logic                              irq_two_is_gpio,
    input  wire sys_pin_pkg::pend_t                pend_clear,
    output sys_pin_pkg::pend_t                     pend_flags,
    output logic                                   fault_irq,
    output logic                                   ext_irq,
    output logic                                   adc_conv_start_in,
    output logic                                   irq_two_gpio_level,
    input  wire logic [15:0]                       system_ctrl_status_reg,
    input  wire logic                              watchdog_clock,
    input  wire logic                              cpu_clock_out_gpio_mode,
    input  wire logic                              cpu_clock_out_gpio_dir_out,
    input  wire logic                              cpu_clock_out_gpio_wr_val,
    input  wire logic                              cpu_clock_out_gpio_wr,
    input  wire logic                              cpu_clock_out_in,
    output logic                                   cpu_clock_out,
    output logic                                   cpu_clock_out_oe,
    output logic                                   cpu_clock_out_gpio_level,
    input  wire logic                              boot_flag_in,
    output logic                                   boot_flag_out,
    output logic                                   boot_flag_oe,
    input  wire logic                              external_flag_set,
    output logic [15:0]                            system_ctrl_status_reg_two,
    input  wire logic                              output_disable_n,
    input  wire logic                              trst,
    input  wire logic                              emulator_io_zero,
    input  wire logic                              crystal_drive_in,
    output logic                                   crystal_drive_out,
    output logic                                   crystal_drive_oe
);
    sys_pin_pkg::rst_state_t state_q;
    logic [7:0]              wd_cnt_q;
    logic                    rpin_level;
    logic                    fa_level;
    logic                    fb_level;
    logic                    i1_level;
    logic                    i2_level;
    logic                    off_level;
    logic                    boot_level;
    logic                    ck_level;
    logic                    fault_a_hit;
    logic                    fault_b_hit;
    logic                    i1_hit;
    logic                    i2_hit;
    logic                    float_a_q;
    logic                    float_b_q;
    logic                    boot_en_q;
    logic                    flag_q;
    logic                    ck_gpio_out_q;
    logic                    ck_gpio_dir_q;
    logic                    in_reset;
    logic                    off_mode;

    pin_sync u_sync_rpin (.mclk(mclk), .rst(rst), .pin(system_reset_pin_in), .level(rpin_level));
    pin_sync u_sync_fa   (.mclk(mclk), .rst(rst), .pin(drive_fault_in_a),    .level(fa_level));
    pin_sync u_sync_fb   (.mclk(mclk), .rst(rst), .pin(drive_fault_in_b),    .level(fb_level));
    pin_sync u_sync_i1   (.mclk(mclk), .rst(rst), .pin(ext_irq_one),         .level(i1_level));
    pin_sync u_sync_i2   (.mclk(mclk), .rst(rst), .pin(ext_irq_two),         .level(i2_level));
    pin_sync u_sync_off  (.mclk(mclk), .rst(rst), .pin(output_disable_n),    .level(off_level));
    pin_sync u_sync_boot (.mclk(mclk), .rst(rst), .pin(boot_flag_in),        .level(boot_level));
    pin_sync u_sync_ck   (.mclk(mclk), .rst(rst), .pin(cpu_clock_out_in),    .level(ck_level));

    // Reset sequencing: pin hold or watchdog pulse
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q  <= sys_pin_pkg::RST_HOLD;
            // Filter starts high, so wait out its latency before trusting the pin
            wd_cnt_q <= 8'(sys_pin_pkg::SYNC_STAGES + 1);
        end else begin
            case (state_q)
                sys_pin_pkg::RST_RUN: begin
                    if (watchdog_overflow) begin
                        state_q  <= sys_pin_pkg::RST_WD_PULSE;
                        wd_cnt_q <= sys_pin_pkg::WD_PULSE_CNT;
                    end else if (!rpin_level) begin
                        state_q <= sys_pin_pkg::RST_HOLD;
                    end
                end
                sys_pin_pkg::RST_HOLD: begin
                    if (wd_cnt_q != 8'h00) begin
                        wd_cnt_q <= wd_cnt_q - 8'h01;
                    end else if (rpin_level) begin
                        state_q <= sys_pin_pkg::RST_RUN;
                    end
                end
                sys_pin_pkg::RST_WD_PULSE: begin
                    if (wd_cnt_q == 8'h01) begin
                        state_q <= sys_pin_pkg::RST_HOLD;
                    end
                    wd_cnt_q <= wd_cnt_q - 8'h01;
                end
                default: begin
                    state_q <= sys_pin_pkg::RST_HOLD;
                end
            endcase
        end
    end

    assign in_reset                    = (state_q != sys_pin_pkg::RST_RUN);
    assign cpu_halt                    = in_reset;
    assign program_counter_clear       = in_reset;
    assign program_counter_reset_value = sys_pin_pkg::PROG_CNT_RESET;
    // Open-drain style: only ever pulls the pin low
    assign system_reset_pin_out        = 1'b0;
    assign system_reset_pin_oe         = (state_q == sys_pin_pkg::RST_WD_PULSE);

    // Fault pins are falling-edge only, polarity fixed
    edge_pend u_fault_a (.mclk(mclk), .rst(rst | in_reset), .level(fa_level), .rise_sel(1'b0),
                         .clear(pend_clear.fault_a), .hit(fault_a_hit), .pend(pend_flags.fault_a));
    edge_pend u_fault_b (.mclk(mclk), .rst(rst | in_reset), .level(fb_level), .rise_sel(1'b0),
                         .clear(pend_clear.fault_b), .hit(fault_b_hit), .pend(pend_flags.fault_b));
    edge_pend u_irq_one (.mclk(mclk), .rst(rst | in_reset), .level(i1_level), .rise_sel(irq_one_rise_sel),
                         .clear(pend_clear.irq_one), .hit(i1_hit), .pend(pend_flags.irq_one));
    edge_pend u_irq_two (.mclk(mclk), .rst(rst | in_reset), .level(i2_level), .rise_sel(irq_two_rise_sel),
                         .clear(pend_clear.irq_two), .hit(i2_hit), .pend(pend_flags.irq_two));

    // Float holds until software releases it; a new edge wins
    always_ff @(posedge mclk) begin
        if (rst || in_reset) begin
            float_a_q <= 1'b0;
        end else if (fault_a_hit) begin
            float_a_q <= 1'b1;
        end else if (fault_release_a) begin
            float_a_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || in_reset) begin
            float_b_q <= 1'b0;
        end else if (fault_b_hit) begin
            float_b_q <= 1'b1;
        end else if (fault_release_b) begin
            float_b_q <= 1'b0;
        end
    end

    // Output disable is qualified by the test-mode pins on the far side
    assign off_mode = ~off_level & ~trst & emulator_io_zero;

    always_comb begin
        event_group_a_pins.out = event_group_a_pwm.out;
        event_group_a_pins.oe  = (float_a_q | fault_a_hit | off_mode) ? '0 : event_group_a_pwm.oe;
        event_group_b_pins.out = event_group_b_pwm.out;
        event_group_b_pins.oe  = (float_b_q | fault_b_hit | off_mode) ? '0 : event_group_b_pwm.oe;
    end

    assign fault_irq          = pend_flags.fault_a | pend_flags.fault_b;
    assign ext_irq            = pend_flags.irq_one | (pend_flags.irq_two & ~irq_two_is_gpio);
    assign adc_conv_start_in  = i2_hit & ~irq_two_is_gpio;
    assign irq_two_gpio_level = i2_level;

    // Clock pin: glitches on select change are accepted, no clock gating cell here
    always_ff @(posedge mclk) begin
        if (rst || in_reset) begin
            ck_gpio_dir_q <= 1'b0;
            ck_gpio_out_q <= 1'b0;
        end else begin
            ck_gpio_dir_q <= cpu_clock_out_gpio_dir_out;
            if (cpu_clock_out_gpio_wr) begin
                ck_gpio_out_q <= cpu_clock_out_gpio_wr_val;
            end
        end
    end

    always_comb begin
        if (!cpu_clock_out_gpio_mode) begin
            cpu_clock_out    = system_ctrl_status_reg[sys_pin_pkg::CLK_SEL_BIT] ? watchdog_clock : mclk;
            cpu_clock_out_oe = ~off_mode;
        end else begin
            cpu_clock_out    = ck_gpio_out_q;
            cpu_clock_out_oe = ck_gpio_dir_q & ~off_mode;
        end
    end
    assign cpu_clock_out_gpio_level = ck_level;

    // Boot level caught while reset is held, flag driven afterward
    always_ff @(posedge mclk) begin
        if (rst) begin
            boot_en_q <= 1'b0;
        end else if (in_reset) begin
            boot_en_q <= boot_level;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || in_reset) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= external_flag_set;
        end
    end

    always_comb begin
        system_ctrl_status_reg_two                           = 16'h0000;
        system_ctrl_status_reg_two[sys_pin_pkg::BOOT_EN_BIT] = boot_en_q;
    end
    assign boot_flag_out = flag_q;
    assign boot_flag_oe  = ~in_reset & ~off_mode;

    assign crystal_drive_out = ~crystal_drive_in;
    assign crystal_drive_oe  = ~off_mode;
endmodule : system_pin_control
`default_nettype wire

// ===== spc_assertions.sv
// Port checker for the system pin control block
`default_nettype none
module spc_chk (
    input wire logic                               mclk,
    input wire logic                               rst,
    input wire logic                               system_reset_pin_in,
    input wire logic                               system_reset_pin_oe,
    input wire logic                               watchdog_overflow,
    input wire logic                               cpu_halt,
    input wire logic                               program_counter_clear,
    input wire logic [sys_pin_pkg::PROG_CNT_WIDTH-1:0] program_counter_reset_value,
    input wire logic                               drive_fault_in_a,
    input wire sys_pin_pkg::pwm_pins_t             event_group_a_pins,
    input wire sys_pin_pkg::pwm_pins_t             event_group_b_pins,
    input wire sys_pin_pkg::pend_t                 pend_flags,
    input wire logic                               fault_irq,
    input wire logic                               irq_two_is_gpio,
    input wire logic                               adc_conv_start_in,
    input wire logic [15:0]                        system_ctrl_status_reg,
    input wire logic                               watchdog_clock,
    input wire logic                               cpu_clock_out_gpio_mode,
    input wire logic                               cpu_clock_out,
    input wire logic                               cpu_clock_out_oe,
    input wire logic                               boot_flag_oe,
    input wire logic                               output_disable_n,
    input wire logic                               trst,
    input wire logic                               emulator_io_zero,
    input wire logic                               crystal_drive_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    // Filter latency plus the state update
    property p_halt; !system_reset_pin_in [*6] |->
        cpu_halt && program_counter_clear && program_counter_reset_value == 16'h0000; endproperty
    a_halt: assert property (p_halt) else $error("core not held in reset");
    // Allows for the three-stage filter plus the state update
    property p_run; system_reset_pin_in [*7] ##0 !system_reset_pin_oe |-> !cpu_halt; endproperty
    a_run: assert property (p_run) else $error("core not running after reset");
    property p_wd; watchdog_overflow && !cpu_halt |=> system_reset_pin_oe [*4] ##1 !system_reset_pin_oe; endproperty
    a_wd: assert property (p_wd) else $error("watchdog pulse length wrong");
    property p_flt_a; $rose(pend_flags.fault_a) |-> fault_irq && event_group_a_pins.oe == 8'h00; endproperty
    a_flt_a: assert property (p_flt_a) else $error("group A not floated");
    property p_flt_b; $rose(pend_flags.fault_b) |-> fault_irq && event_group_b_pins.oe == 8'h00; endproperty
    a_flt_b: assert property (p_flt_b) else $error("group B not floated");
    property p_lvl; !drive_fault_in_a [*8] |=> !$rose(pend_flags.fault_a); endproperty
    a_lvl: assert property (p_lvl) else $error("fault level retriggered");
    property p_adc; adc_conv_start_in |-> !irq_two_is_gpio ##1 (!adc_conv_start_in && pend_flags.irq_two); endproperty
    a_adc: assert property (p_adc) else $error("conversion start malformed");
    property p_clk; !cpu_clock_out_gpio_mode && system_ctrl_status_reg[14] |->
        cpu_clock_out_oe && cpu_clock_out == watchdog_clock; endproperty
    a_clk: assert property (p_clk) else $error("clock pin not watchdog clock");
    property p_flag; cpu_halt [*2] |-> !boot_flag_oe; endproperty
    a_flag: assert property (p_flag) else $error("flag driven during reset");
    property p_gpio; cpu_halt [*2] ##0 cpu_clock_out_gpio_mode |-> !cpu_clock_out_oe; endproperty
    a_gpio: assert property (p_gpio) else $error("gpio driving during reset");
    property p_off; (!output_disable_n && !trst && emulator_io_zero) [*5] |-> !crystal_drive_oe; endproperty
    a_off: assert property (p_off) else $error("crystal driver not released");
    // Test-reset pin acts at once, the disable pin only through its filter
    property p_on; (output_disable_n [*5] or trst) |-> crystal_drive_oe; endproperty
    a_on: assert property (p_on) else $error("crystal driver off wrongly");
endmodule : spc_chk

bind system_pin_control spc_chk i_spc_chk (.*);
`default_nettype wire

// ===== spc_partner.sv
// Far-side model: reset circuit, clock pin load pulled up when undriven, and boot strap
`default_nettype none
module spc_partner (
    input  wire logic button_n,
    input  wire logic system_reset_pin_out,
    input  wire logic system_reset_pin_oe,
    output logic      system_reset_pin_in,
    input  wire logic clk_pin_drive,
    input  wire logic clk_pin_drive_en,
    input  wire logic cpu_clock_out,
    input  wire logic cpu_clock_out_oe,
    output logic      cpu_clock_out_in,
    input  wire logic boot_strap,
    input  wire logic boot_flag_out,
    input  wire logic boot_flag_oe,
    output logic      boot_flag_in
);
    // Open-drain reset line, so a watchdog pulse shows outside
    assign system_reset_pin_in = (system_reset_pin_oe && !system_reset_pin_out) ? 1'b0 : button_n;
    assign cpu_clock_out_in = cpu_clock_out_oe ? cpu_clock_out : (clk_pin_drive_en ? clk_pin_drive : 1'b1);
    assign boot_flag_in = boot_flag_oe ? boot_flag_out : boot_strap;
endmodule : spc_partner
`default_nettype wire

// ===== system_pin_control_tb_top.sv
// Self-checking bench for the system pin control block
`default_nettype none
module system_pin_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst, watchdog_overflow, drive_fault_in_a, drive_fault_in_b, fault_release_a, fault_release_b;
    logic ext_irq_one, ext_irq_two, irq_one_rise_sel, irq_two_rise_sel, irq_two_is_gpio, watchdog_clock;
    logic cpu_clock_out_gpio_mode, cpu_clock_out_gpio_dir_out, cpu_clock_out_gpio_wr_val, cpu_clock_out_gpio_wr, external_flag_set;
    logic output_disable_n, trst, emulator_io_zero, crystal_drive_in, button_n, clk_pin_drive, clk_pin_drive_en;
    logic boot_strap, system_reset_pin_in, system_reset_pin_out, system_reset_pin_oe, cpu_halt;
    logic program_counter_clear, fault_irq, ext_irq, adc_conv_start_in, irq_two_gpio_level, cpu_clock_out;
    logic cpu_clock_out_oe, cpu_clock_out_gpio_level, cpu_clock_out_in, boot_flag_out, boot_flag_oe;
    logic boot_flag_in, crystal_drive_out, crystal_drive_oe;
    logic [1:0] wdc = 2'h0;
    logic [15:0] system_ctrl_status_reg, system_ctrl_status_reg_two, program_counter_reset_value;
    sys_pin_pkg::pwm_pins_t event_group_a_pwm, event_group_b_pwm, event_group_a_pins, event_group_b_pins;
    sys_pin_pkg::pend_t pend_clear, pend_flags;
    int n_errors = 0, cmp_count = 0, cyc_cnt = 0, adc_cnt = 0;

    system_pin_control i_system_pin_control (.*);
    spc_partner i_spc_partner (.*);

    initial begin
        mclk = 0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        wdc <= wdc + 2'h1;
        watchdog_clock <= wdc[1];
        if (adc_conv_start_in === 1'b1) adc_cnt++;
        cyc_cnt++;
        if (cyc_cnt == 3000) begin
            n_errors++;
            give_verdict();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc
    task automatic give_verdict();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    task automatic t_reset();
        cyc(8); #1 chk(cpu_halt, 1'h1);
        chk(program_counter_clear, 1'h1);
        chk(program_counter_reset_value, 16'h0000);
        chk(system_ctrl_status_reg_two, 16'h0008);
        chk(boot_flag_oe, 1'h0);
        cyc(1); button_n <= 1;
        cyc(8); #1 chk(cpu_halt, 1'h0);
        chk(boot_flag_oe, 1'h1);
        chk(boot_flag_out, 1'h1);
        cyc(1); external_flag_set <= 0; boot_strap <= 0;
        cyc(6); #1 chk(boot_flag_out, 1'h0);
        chk(system_ctrl_status_reg_two, 16'h0008);
        $display("Test reset done");
    endtask : t_reset

    task automatic t_wdog();
        int n;
        cyc(1); cpu_clock_out_gpio_dir_out <= 1; cpu_clock_out_gpio_wr_val <= 1; cpu_clock_out_gpio_wr <= 1;
        cyc(1); cpu_clock_out_gpio_wr <= 0;
        cyc(3); #1 chk(cpu_clock_out_oe, 1'h1);
        chk(cpu_clock_out, 1'h1);
        cyc(1); watchdog_overflow <= 1;
        cyc(1); watchdog_overflow <= 0;
        n = 0;
        repeat (8) begin
            #1 n += (system_reset_pin_oe === 1'b1 && system_reset_pin_in === 1'b0 && cpu_halt === 1'b1);
            @(posedge mclk);
        end
        chk(n[15:0], 16'(sys_pin_pkg::WD_PULSE_CYCLES));
        #1 chk(cpu_clock_out_oe, 1'h0);
        cyc(8); #1 chk(cpu_halt, 1'h0);
        $display("Test watchdog done");
    endtask : t_wdog

    task automatic t_fault(input bit b);
        sys_pin_pkg::pend_t m;
        m = b ? 4'h4 : 4'h8;
        cyc(1); if (b) drive_fault_in_b <= 0; else drive_fault_in_a <= 0;
        cyc(8); #1 chk(pend_flags, m);
        chk(fault_irq, 1'h1);
        chk(b ? event_group_b_pins : event_group_a_pins, b ? 16'h5A00 : 16'hA500);
        chk(b ? event_group_a_pins : event_group_b_pins, b ? 16'hA5FF : 16'h5AFF);
        cyc(1); pend_clear <= m;
        cyc(1); pend_clear <= 4'h0;
        cyc(10); #1 chk(pend_flags, 4'h0);
        cyc(1); fault_release_a <= 1; fault_release_b <= 1; drive_fault_in_a <= 1; drive_fault_in_b <= 1;
        cyc(1); fault_release_a <= 0; fault_release_b <= 0;
        cyc(8); #1 chk(event_group_a_pins, 16'hA5FF);
        chk(event_group_b_pins, 16'h5AFF);
        chk(pend_flags, 4'h0);
        $display("Test fault done");
    endtask : t_fault

    task automatic t_irq();
        logic p;
        int a0;
        for (int i = 0; i < 4; i++) begin
            p = i[0];
            cyc(1); irq_one_rise_sel <= p; irq_two_rise_sel <= p; ext_irq_one <= ~p; ext_irq_two <= ~p;
            cyc(8); pend_clear <= 4'h3; a0 = adc_cnt;
            cyc(1); pend_clear <= 4'h0;
            if (i[1]) ext_irq_two <= p; else ext_irq_one <= p;
            cyc(8); #1 chk(pend_flags, i[1] ? 4'h1 : 4'h2);
            chk(ext_irq, 1'h1);
            chk(16'(adc_cnt - a0), {15'h0000, i[1]});
            cyc(1); pend_clear <= 4'h3;
            cyc(1); pend_clear <= 4'h0; ext_irq_one <= ~p; ext_irq_two <= ~p;
            cyc(8); #1 chk(pend_flags, 4'h0);
        end
        cyc(1); irq_two_is_gpio <= 1; a0 = adc_cnt; ext_irq_two <= 1;
        cyc(8); #1 chk(irq_two_gpio_level, 1'h1);
        chk(16'(adc_cnt - a0), 16'h0000);
        cyc(1); irq_two_is_gpio <= 0;
        $display("Test irq done");
    endtask : t_irq

    task automatic t_clk();
        cyc(1); cpu_clock_out_gpio_mode <= 0; system_ctrl_status_reg <= 16'h4000;
        cyc(2);
        repeat (6) @(negedge mclk) chk(cpu_clock_out, watchdog_clock);
        cyc(1); system_ctrl_status_reg <= 16'h0000;
        repeat (3) begin
            @(negedge mclk) #1 chk(cpu_clock_out, 1'h0);
            @(posedge mclk) #1 chk(cpu_clock_out, 1'h1);
        end
        cyc(1); cpu_clock_out_gpio_mode <= 1; cpu_clock_out_gpio_dir_out <= 0; cpu_clock_out_gpio_wr <= 1;
        clk_pin_drive_en <= 1; clk_pin_drive <= 0;
        cyc(1); cpu_clock_out_gpio_wr <= 0;
        cyc(8); #1 chk(cpu_clock_out_oe, 1'h0);
        chk(cpu_clock_out_gpio_level, 1'h0);
        $display("Test clock pin done");
    endtask : t_clk

    task automatic t_off();
        cyc(1); output_disable_n <= 0;
        cyc(8); #1 chk(crystal_drive_oe, 1'h0);
        cyc(1); trst <= 1;
        cyc(2); #1 chk(crystal_drive_oe, 1'h1);
        cyc(1); trst <= 0; output_disable_n <= 1;
        cyc(8); #1 chk(crystal_drive_oe, 1'h1);
        chk(crystal_drive_out, 1'h0);
        $display("Test output disable done");
    endtask : t_off

    initial begin
        {rst, button_n, boot_strap, trst, emulator_io_zero, output_disable_n, crystal_drive_in} = 7'h57;
        {watchdog_overflow, fault_release_a, fault_release_b, irq_one_rise_sel, irq_two_rise_sel} = 5'h00;
        {drive_fault_in_a, drive_fault_in_b, ext_irq_one, ext_irq_two, irq_two_is_gpio} = 5'h1E;
        {cpu_clock_out_gpio_mode, cpu_clock_out_gpio_dir_out, cpu_clock_out_gpio_wr_val, cpu_clock_out_gpio_wr} = 4'h8;
        {external_flag_set, clk_pin_drive, clk_pin_drive_en} = 3'h4;
        system_ctrl_status_reg = 16'h0000;
        event_group_a_pwm = 16'hA5FF;
        event_group_b_pwm = 16'h5AFF;
        pend_clear = 4'h0;
        cyc(20); rst <= 0;
        t_reset();
        t_wdog();
        t_fault(1'b0);
        t_fault(1'b1);
        t_irq();
        t_clk();
        t_off();
        give_verdict();
    end
endmodule : system_pin_control_tb_top
`default_nettype wire
